// *** include/serializer_defs.svh ***
// constants and timing counts for the 21-to-3 pixel serializer link
`ifndef SERIALIZER_DEFS_SVH
`define SERIALIZER_DEFS_SVH

// word geometry
`define PIXEL_BITS        21
`define LANE_COUNT        3
`define BITS_PER_LANE     7
`define CLK_HIGH_SLOTS    4

// core clock
`define CORE_PERIOD_NS    50

// input clock limits kept by the source
`define PCLK_MIN_MHZ      31
`define PCLK_MAX_MHZ      75

// core cycles per serial bit slot
`define SLOT_CYCLES       1

// buffering between capture and serializer
`define FIFO_DEPTH        16

// lock: falling edges seen before words count as valid
`define LOCK_EDGES        2
`define LOCK_TIME_NS      1000000
`define LOCK_TIME_CYC     (`LOCK_TIME_NS / `CORE_PERIOD_NS)

// off time after shutdown falls, in picoseconds; longest time rounds down, at least one cycle
`define OFF_TIME_PS       6500
`define OFF_TIME_CYC      (((`OFF_TIME_PS / (`CORE_PERIOD_NS * 1000)) < 1) ? 1 : (`OFF_TIME_PS / (`CORE_PERIOD_NS * 1000)))

`endif

// *** include/serializer_pkg.sv ***
// shared types for the pixel serializer link
package serializer_pkg;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

  typedef enum logic [0:0] {
    RX_WAIT    = 1'b0,
    RX_COLLECT = 1'b1
  } rx_state_t;

  typedef logic [6:0] lane_slice_t;

endpackage

// *** include/pixel_link_if.sv ***
// serial link between transmitter and receiver: three lanes plus forwarded clock
`timescale 1ns/1ps
`default_nettype none
interface pixel_link_if;
  logic [2:0] serial_lane_outputs;
  logic       lane_oe;
  logic       forwarded_link_clock;
  logic       clock_oe;

  modport tx (
    output serial_lane_outputs,
    output lane_oe,
    output forwarded_link_clock,
    output clock_oe
  );

  modport rx (
    input serial_lane_outputs,
    input lane_oe,
    input forwarded_link_clock,
    input clock_oe
  );
endinterface
`default_nettype wire

// *** hw/pixel_tx.sv ***
// serializer transmitter end with its capture FIFO
`include "serializer_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = `PIXEL_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !(wr_ptr_r[AW] != rd_ptr_r[AW] && wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only pointers define content
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  // pointers; clr empties the buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (clr)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

module pixel_tx #(
  parameter int SLOT_CYC   = `SLOT_CYCLES,
  parameter int LOCK_EDGES = `LOCK_EDGES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // core clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  // source side pins
  input  wire logic                   INPUT_PIXEL_CLOCK,
  input  wire logic [`PIXEL_BITS-1:0] PARALLEL_PIXEL_BITS,
  input  wire logic                   SHUTDOWN_CLEAR_N,
  // status
  output logic                        TX_LOCKED,
  output logic                        TX_OVERRUN,
  // serial link
  pixel_link_if.tx                    link
);
  generate
    if (SLOT_CYC < 1 || SLOT_CYC > 256 || LOCK_EDGES < 1 || LOCK_EDGES > 255)
    begin : g_bad_param
      $error("slot cycles and lock edges out of range");
    end
  endgenerate

  // slice of the word that belongs to one lane
  function automatic serializer_pkg::lane_slice_t slice_of(input logic [`PIXEL_BITS-1:0] w, input int lane);
    slice_of = w[lane*`BITS_PER_LANE +: `BITS_PER_LANE];
  endfunction

  // pin synchronisers
  logic                   pclk_s1_r, pclk_s2_r, pclk_s3_r;
  logic                   sd_s1_r, sd_n_r;
  logic [`PIXEL_BITS-1:0] dat_s1_r, dat_s2_r;
  // capture and lock
  logic [`PIXEL_BITS-1:0] cap_r;
  logic                   cap_vld_r;
  logic [7:0]             edge_cnt_r;
  logic                   locked_r;
  logic                   overrun_r;
  logic                   fall;
  // fifo drain side
  logic [`PIXEL_BITS-1:0] fifo_data;
  logic                   fifo_valid;
  logic                   fifo_ready;
  logic                   fifo_in_ready;
  // serializer
  serializer_pkg::tx_state_t   state_r;
  serializer_pkg::lane_slice_t sh_r [`LANE_COUNT];
  logic [2:0]                  slot_r;
  logic [7:0]                  sub_r;
  logic [2:0]                  lane_r;
  logic                        fclk_r;
  logic                        oe_r;
  logic                        slot_end;
  logic                        frame_end;

  // two flops on every pin before use
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
      sd_s1_r   <= 1'b0;
      sd_n_r    <= 1'b0;
      dat_s1_r  <= '0;
      dat_s2_r  <= '0;
    end
    else
    begin
      pclk_s1_r <= INPUT_PIXEL_CLOCK;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
      sd_s1_r   <= SHUTDOWN_CLEAR_N;
      sd_n_r    <= sd_s1_r;
      dat_s1_r  <= PARALLEL_PIXEL_BITS;
      dat_s2_r  <= dat_s1_r;
    end
  end

  // data is synchronised with the same latency as the clock, so it lines up with the edge
  assign fall = pclk_s3_r && !pclk_s2_r;

  // lock: a few clean falling edges after shutdown release before words count
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      edge_cnt_r <= 8'h00;
      locked_r   <= 1'b0;
    end
    else if (!sd_n_r)
    begin
      edge_cnt_r <= 8'h00;
      locked_r   <= 1'b0;
    end
    else if (fall && !locked_r)
    begin
      edge_cnt_r <= edge_cnt_r + 8'h01;
      locked_r   <= (edge_cnt_r == 8'(LOCK_EDGES - 1));
    end
  end

  // capture all bits on each falling edge once locked; a pending word blocks the next only while the fifo is full
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cap_r     <= '0;
      cap_vld_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else if (!sd_n_r)
    begin
      cap_r     <= '0;
      cap_vld_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (fall && locked_r && (!cap_vld_r || fifo_in_ready))
      begin
        cap_r     <= dat_s2_r;
        cap_vld_r <= 1'b1;
      end
      else if (cap_vld_r && fifo_in_ready)
        cap_vld_r <= 1'b0;
      // sticky: word lost because the fifo stalled capture
      if (fall && locked_r && cap_vld_r && !fifo_in_ready)
        overrun_r <= 1'b1;
    end
  end

  word_fifo #(
    .WIDTH (`PIXEL_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (NRST),
    .clr       (!sd_n_r),
    .in_data   (cap_r),
    .in_valid  (cap_vld_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // slot timing: the frame of seven slots is this block's shift clock
  assign slot_end   = (sub_r == 8'(SLOT_CYC - 1));
  assign frame_end  = slot_end && (slot_r == 3'(`BITS_PER_LANE - 1));
  assign fifo_ready = sd_n_r && ((state_r == serializer_pkg::TX_IDLE) ||
                      (state_r == serializer_pkg::TX_SHIFT && frame_end));

  // serializer: one frame per captured word keeps link clock at input clock rate
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r <= serializer_pkg::TX_IDLE;
      slot_r  <= 3'h0;
      sub_r   <= 8'h00;
      lane_r  <= 3'h0;
      fclk_r  <= 1'b0;
      for (int l = 0; l < `LANE_COUNT; l++)
        sh_r[l] <= 7'h00;
    end
    else if (!sd_n_r)
    begin
      state_r <= serializer_pkg::TX_IDLE;
      slot_r  <= 3'h0;
      sub_r   <= 8'h00;
      lane_r  <= 3'h0;
      fclk_r  <= 1'b0;
      for (int l = 0; l < `LANE_COUNT; l++)
        sh_r[l] <= 7'h00;
    end
    else if (fifo_valid && fifo_ready)
    begin
      // load: slot 0 goes out with the clock's rising edge
      state_r <= serializer_pkg::TX_SHIFT;
      slot_r  <= 3'h0;
      sub_r   <= 8'h00;
      fclk_r  <= 1'b1;
      for (int l = 0; l < `LANE_COUNT; l++)
      begin
        lane_r[l] <= fifo_data[l*`BITS_PER_LANE];
        sh_r[l]   <= slice_of(fifo_data, l) >> 1;
      end
    end
    else
    begin
      unique case (state_r)
        serializer_pkg::TX_IDLE:
        begin
          fclk_r <= 1'b0;
          lane_r <= 3'h0;
        end
        serializer_pkg::TX_SHIFT:
        begin
          if (!slot_end)
            sub_r <= sub_r + 8'h01;
          else if (frame_end)
          begin
            // nothing queued: clock parks low until the next word
            state_r <= serializer_pkg::TX_IDLE;
            sub_r   <= 8'h00;
            fclk_r  <= 1'b0;
            lane_r  <= 3'h0;
          end
          else
          begin
            sub_r  <= 8'h00;
            slot_r <= slot_r + 3'h1;
            fclk_r <= ((slot_r + 3'h1) < 3'(`CLK_HIGH_SLOTS));
            for (int l = 0; l < `LANE_COUNT; l++)
            begin
              lane_r[l] <= sh_r[l][0];
              sh_r[l]   <= sh_r[l] >> 1;
            end
          end
        end
      endcase
    end
  end

  // drivers follow shutdown; off takes the synchroniser latency plus one cycle
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      oe_r <= 1'b0;
    else
      oe_r <= sd_n_r;
  end

  // outputs straight from flops
  assign link.serial_lane_outputs  = lane_r;
  assign link.forwarded_link_clock = fclk_r;
  assign link.lane_oe              = oe_r;
  assign link.clock_oe             = oe_r;
  assign TX_LOCKED                 = locked_r;
  assign TX_OVERRUN                = overrun_r;
endmodule
`default_nettype wire

// *** hw/pixel_rx.sv ***
// deserializing receiver end of the pixel link
`include "serializer_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pixel_rx #(
  parameter int SLOT_CYC = `SLOT_CYCLES
) (
  // core clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  // serial link
  pixel_link_if.rx                    link,
  // user side
  output logic [`PIXEL_BITS-1:0]      RX_PIXEL_BITS,
  output logic                        RX_WORD_VALID,
  output logic                        RX_LINK_UP
);
  generate
    if (SLOT_CYC < 1 || SLOT_CYC > 255)
    begin : g_bad_param
      $error("slot cycles out of range");
    end
  endgenerate

  logic [2:0]                lane_s1_r, lane_s2_r;
  logic                      fclk_s1_r, fclk_s2_r, fclk_s3_r;
  logic                      oe_s1_r, oe_s2_r;
  serializer_pkg::rx_state_t state_r;
  logic [2:0]                slot_r;
  logic [7:0]                sub_r;
  logic [`PIXEL_BITS-1:0]    acc_r;
  logic [`PIXEL_BITS-1:0]    word_r;
  logic                      vld_r;
  logic                      rise;

  // every link wire passes two flops; lanes and clock share latency
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      lane_s1_r <= 3'h0;
      lane_s2_r <= 3'h0;
      fclk_s1_r <= 1'b0;
      fclk_s2_r <= 1'b0;
      fclk_s3_r <= 1'b0;
      oe_s1_r   <= 1'b0;
      oe_s2_r   <= 1'b0;
    end
    else
    begin
      lane_s1_r <= link.serial_lane_outputs;
      lane_s2_r <= lane_s1_r;
      fclk_s1_r <= link.forwarded_link_clock && link.clock_oe;
      fclk_s2_r <= fclk_s1_r;
      fclk_s3_r <= fclk_s2_r;
      oe_s1_r   <= link.lane_oe;
      oe_s2_r   <= oe_s1_r;
    end
  end

  assign rise = fclk_s2_r && !fclk_s3_r;

  // bit 0 is present at the clock rise; later bits follow one slot apart
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r <= serializer_pkg::RX_WAIT;
      slot_r  <= 3'h0;
      sub_r   <= 8'h00;
      acc_r   <= '0;
      word_r  <= '0;
      vld_r   <= 1'b0;
    end
    else
    begin
      vld_r <= 1'b0;
      if (!oe_s2_r)
      begin
        // drivers off: drop any partial word
        state_r <= serializer_pkg::RX_WAIT;
        acc_r   <= '0;
      end
      else
      begin
        unique case (state_r)
          serializer_pkg::RX_WAIT:
          begin
            if (rise)
            begin
              state_r <= serializer_pkg::RX_COLLECT;
              slot_r  <= 3'h1;
              sub_r   <= 8'h00;
              for (int l = 0; l < `LANE_COUNT; l++)
                acc_r[l*`BITS_PER_LANE] <= lane_s2_r[l];
            end
          end
          serializer_pkg::RX_COLLECT:
          begin
            if (sub_r != 8'(SLOT_CYC - 1))
              sub_r <= sub_r + 8'h01;
            else
            begin
              sub_r <= 8'h00;
              for (int l = 0; l < `LANE_COUNT; l++)
                acc_r[l*`BITS_PER_LANE + int'(slot_r)] <= lane_s2_r[l];
              if (slot_r == 3'(`BITS_PER_LANE - 1))
              begin
                state_r <= serializer_pkg::RX_WAIT;
                vld_r   <= 1'b1;
                for (int l = 0; l < `LANE_COUNT; l++)
                begin
                  word_r[l*`BITS_PER_LANE +: `BITS_PER_LANE - 1] <= acc_r[l*`BITS_PER_LANE +: `BITS_PER_LANE - 1];
                  word_r[l*`BITS_PER_LANE + `BITS_PER_LANE - 1]  <= lane_s2_r[l];
                end
              end
              else
                slot_r <= slot_r + 3'h1;
            end
          end
        endcase
      end
    end
  end

  assign RX_PIXEL_BITS = word_r;
  assign RX_WORD_VALID = vld_r;
  assign RX_LINK_UP    = oe_s2_r;
endmodule
`default_nettype wire

// *** tb/pixel_serializer_21to3_props.sv ***
// checker for the serial link: frame shape, driver enables and idle levels
`timescale 1ns/1ps
`default_nettype none
module link_props (
  // clock and reset
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  // link signals
  input wire logic [2:0] serial_lane_outputs,
  input wire logic       lane_oe,
  input wire logic       forwarded_link_clock,
  input wire logic       clock_oe
);
  logic       fclk_q_r;
  logic [2:0] slot_r;
  logic       rise;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  // slot position since the last clock rise, so lane activity can be placed in a frame
  assign rise = forwarded_link_clock & ~fclk_q_r;
  always_ff @(posedge CORE_CLK or negedge NRST)
    if (!NRST)
      fclk_q_r <= 1'b0;
    else
      fclk_q_r <= forwarded_link_clock;
  always_ff @(posedge CORE_CLK or negedge NRST)
    if (!NRST)
      slot_r <= 3'h0;
    else if (rise)
      slot_r <= 3'h1;
    else if (slot_r != 3'h0 && slot_r < 3'h6)
      slot_r <= slot_r + 3'h1;
    else
      slot_r <= 3'h0;

  // a frame is four slots high then three low
  sequence s_high;
    forwarded_link_clock [*4];
  endsequence
  sequence s_low;
    (!forwarded_link_clock) [*3];
  endsequence

  property p_oe_pair;
    clock_oe == lane_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock and lane enables differ");
  // an abort by shutdown cuts the frame short, so the shape only binds while driving
  property p_frame;
    disable iff (!NRST || !lane_oe) $rose(forwarded_link_clock) |-> s_high ##1 s_low;
  endproperty
  a_frame: assert property (p_frame) else $error("forwarded clock frame shape wrong");
  property p_spacing;
    $rose(forwarded_link_clock) |=> (!$rose(forwarded_link_clock)) [*6];
  endproperty
  a_spacing: assert property (p_spacing) else $error("clock rises closer than seven slots");
  property p_off_clk;
    !lane_oe |-> !forwarded_link_clock;
  endproperty
  a_off_clk: assert property (p_off_clk) else $error("clock high with drivers off");
  property p_off_lanes;
    !lane_oe |-> serial_lane_outputs == 3'h0;
  endproperty
  a_off_lanes: assert property (p_off_lanes) else $error("lanes not cleared with drivers off");
  property p_idle;
    serial_lane_outputs != 3'h0 |-> rise || slot_r != 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lane data outside a frame");
  property p_oe_rise_clean;
    $rose(lane_oe) |-> !forwarded_link_clock && serial_lane_outputs == 3'h0;
  endproperty
  a_oe_rise_clean: assert property (p_oe_rise_clean) else $error("drivers start from stale state");
  property p_rise_needs_oe;
    $rose(forwarded_link_clock) |-> $past(lane_oe);
  endproperty
  a_rise_needs_oe: assert property (p_rise_needs_oe) else $error("clock started before drivers on");
endmodule
`default_nettype wire

// *** tb/test_pixel_serializer_21to3.sv ***
// bench: transmitter and receiver joined across the link, words compared end to end
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module test_pixel_serializer_21to3;
  typedef struct packed {logic [20:0] din; logic [20:0] exp;} row_t;
  // boundary words: all zero, all one, alternating, first and last slot of lane 0, first slot of lane 1, last slot of lane 2
  row_t        rows [8] = '{'{21'h00_0000, 21'h00_0000}, '{21'h1f_ffff, 21'h1f_ffff},
                            '{21'h15_5555, 21'h15_5555}, '{21'h0a_aaaa, 21'h0a_aaaa},
                            '{21'h00_0001, 21'h00_0001}, '{21'h00_0040, 21'h00_0040},
                            '{21'h00_0080, 21'h00_0080}, '{21'h10_0000, 21'h10_0000}};
  logic        core_clk;
  logic        nrst;
  logic        pix_clk;
  logic        shut_n;
  logic [20:0] pix_bits;
  logic        tx_locked;
  logic        tx_overrun;
  logic [20:0] rx_bits;
  logic        rx_valid;
  logic        rx_up;
  logic [20:0] want_rx;
  logic [20:0] want_wire;
  logic [20:0] wire_w;
  logic        fclk_q = 1'b0;
  logic [20:0] exp_q [$];
  logic [20:0] wire_q [$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          rises = 0;
  int          sent = 0;
  int          slot = 7;
  bit          armed = 1'b0;

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  pixel_link_if pixel_link_if_i ();
  pixel_tx #(.SLOT_CYC(1), .LOCK_EDGES(2), .FIFO_DEPTH(16)) pixel_tx_i (
    .CORE_CLK(core_clk), .NRST(nrst), .INPUT_PIXEL_CLOCK(pix_clk), .PARALLEL_PIXEL_BITS(pix_bits),
    .SHUTDOWN_CLEAR_N(shut_n), .TX_LOCKED(tx_locked), .TX_OVERRUN(tx_overrun), .link(pixel_link_if_i.tx));
  pixel_rx #(.SLOT_CYC(1)) pixel_rx_i (
    .CORE_CLK(core_clk), .NRST(nrst), .link(pixel_link_if_i.rx),
    .RX_PIXEL_BITS(rx_bits), .RX_WORD_VALID(rx_valid), .RX_LINK_UP(rx_up));
  link_props link_props_i (
    .CORE_CLK(core_clk), .NRST(nrst), .serial_lane_outputs(pixel_link_if_i.serial_lane_outputs),
    .lane_oe(pixel_link_if_i.lane_oe), .forwarded_link_clock(pixel_link_if_i.forwarded_link_clock),
    .clock_oe(pixel_link_if_i.clock_oe));

  // receiver side: each fresh word is the next one sent, and nothing else arrives
  // sampled on the falling edge, away from the edge that launches the flops
  always @(negedge core_clk)
    if (armed && rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHECK(rx_valid, 1'b0)
      else
      begin
        want_rx = exp_q.pop_front();
        `CHECK(rx_bits, want_rx)
      end
    end

  // wire side: rebuild the word from seven slots per lane, bit 0 at the clock rise
  always @(negedge core_clk)
  begin
    fclk_q <= pixel_link_if_i.forwarded_link_clock;
    if (armed && pixel_link_if_i.forwarded_link_clock === 1'b1 && fclk_q === 1'b0)
    begin
      slot = 0;
      rises++;
    end
    if (slot < 7)
    begin
      for (int n = 0; n < 3; n++)
        wire_w[7*n+slot] = pixel_link_if_i.serial_lane_outputs[n];
      slot++;
      if (slot == 7 && armed && wire_q.size() > 0)
      begin
        want_wire = wire_q.pop_front();
        `CHECK(wire_w, want_wire)
      end
    end
  end

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up();
    bad_count++;
    $display("ERROR t=%0t wait bound used up", $time);
    stop_test();
  endtask

  // one pixel clock period of 400 ns, data held four cycles each side of the fall
  task automatic send(input logic [20:0] w, input logic [20:0] e, input bit push);
    @(negedge core_clk);
    pix_bits = w;
    pix_clk = 1'b1;
    repeat (4) @(negedge core_clk);
    pix_clk = 1'b0;
    if (push)
    begin
      exp_q.push_back(e);
      wire_q.push_back(e);
      sent++;
    end
    repeat (3) @(negedge core_clk);
  endtask

  // lock on two dummy falls; lock comes with the second, so neither word is captured, and the queues are cleared unchecked
  task automatic relock();
    int i;
    armed = 1'b0;
    send(21'h00_0000, 21'h00_0000, 1'b0);
    send(21'h00_0000, 21'h00_0000, 1'b0);
    for (i = 0; i < 100 && tx_locked !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 100)
      give_up();
    repeat (40) @(negedge core_clk);
    exp_q.delete();
    wire_q.delete();
    sent = 0;
    rises = 0;
    armed = 1'b1;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 300 && exp_q.size() > 0; i++)
      @(negedge core_clk);
    if (i == 300)
      give_up();
  endtask

  initial
  begin
    int i;
    nrst = 1'b0;
    pix_clk = 1'b0;
    pix_bits = 21'h00_0000;
    shut_n = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHECK({tx_locked, tx_overrun, rx_valid, rx_up, rx_bits}, 25'h000_0000)
    `CHECK(pixel_link_if_i.lane_oe, 1'b0)
    nrst = 1'b1;
    relock();
    `CHECK(rx_up, 1'b1)
    foreach (rows[k])
      send(rows[k].din, rows[k].exp, 1'b1);
    drain();
    `CHECK(rises, sent)
    `CHECK(tx_overrun, 1'b0)
    // shutdown in mid-frame: the word is lost, drivers go off, state clears
    send(21'h1f_ffff, 21'h1f_ffff, 1'b0);
    for (i = 0; i < 50 && pixel_link_if_i.forwarded_link_clock !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 50)
      give_up();
    shut_n = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHECK(pixel_link_if_i.lane_oe, 1'b0)
    `CHECK(pixel_link_if_i.forwarded_link_clock, 1'b0)
    `CHECK(pixel_link_if_i.serial_lane_outputs, 3'h0)
    send(21'h0a_aaaa, 21'h0a_aaaa, 1'b0);
    repeat (20) @(negedge core_clk);
    `CHECK(tx_locked, 1'b0)
    `CHECK(rx_up, 1'b0)
    // after release the link locks again and carries data
    shut_n = 1'b1;
    relock();
    send(rows[2].din, rows[2].exp, 1'b1);
    send(rows[7].din, rows[7].exp, 1'b1);
    drain();
    `CHECK(rises, sent)
    stop_test();
  end
endmodule
`default_nettype wire
